// ---- smcm_regs.vh ----
/*
 Constants of the selector channel maintenance board: control word field
 positions, counter selections, buffer load codes, unit numbers and timeout.
 Assumes the control word arrives with bit 0 as the most significant bit.
*/
`ifndef SMCM_REGS_VH
`define SMCM_REGS_VH

// Control word bit n sits at index 15-n
`define SMCM_CW_MCLR      15
`define SMCM_CW_RST_INT   14
`define SMCM_CW_SET_JMP   13
`define SMCM_CW_DEV_END   12
`define SMCM_CW_INH_ACK   11
`define SMCM_CW_INH_SR    10
`define SMCM_CW_LOAD_HI   9
`define SMCM_CW_LOAD_LO   8
`define SMCM_CW_HS_SR     7
`define SMCM_CW_UNIT_BUF  6
`define SMCM_CW_TERM_TC   5
`define SMCM_CW_TERM_CMP  4
`define SMCM_CW_CLR_IF    3
`define SMCM_CW_CNT_HI    2
`define SMCM_CW_CNT_LO    0
`define SMCM_CW_RESET     16'h0000

// Buffer load codes, control word bits 6 and 7
`define SMCM_LD_IGNORE    2'h0
`define SMCM_LD_ORDER     2'h1
`define SMCM_LD_ADDR      2'h2
`define SMCM_LD_BOTH      2'h3

// Counter selections, control word bits 13 to 15
`define SMCM_CNT_NONE     3'h0
`define SMCM_CNT_NEXT     3'h1
`define SMCM_CNT_PRD      3'h2
`define SMCM_CNT_INTOG    3'h3
`define SMCM_CNT_PWR      3'h4
`define SMCM_CNT_OUTTOG   3'h5
`define SMCM_CNT_END      3'h6
`define SMCM_CNT_SO       3'h7

`define SMCM_MUX_UNIT     7'h7F
`define SMCM_SEL_UNIT     7'h10
`define SMCM_BUF_RESET    16'h0000
`define SMCM_CNT_RESET    16'h0000

// Memory module response timeout
`define SMCM_CLK_MHZ      50
`define SMCM_TIMEOUT_US   10
`define SMCM_TIMEOUT_CYC  (`SMCM_TIMEOUT_US * `SMCM_CLK_MHZ)

`endif

// ---- smcm_board.v ----
/*
 Selector channel maintenance board: control word decode, data buffer,
 strobe counter, transfer termination, port timeout and service requests.
 Assumes all channel strobes are one-cycle pulses synchronous to core_clk
 and that straps are stable while resetn is released.
*/
// Functional notes
// - Bit 0 master clears; bit 1 clears interrupt
// - Bit 8 drives high-speed service request
// - Bit 10 ends transfer at terminal count
// - Bit 11 ends transfer on compare failure
// - Bits 6-7 choose how orders load buffer
// - Bits 13-15 choose which strobe is counted
// - Memory timeout becomes transfer fault, interrupt
// - Multiplexer: no interrupt, unit 127 only
// - Bus parity error never flagged, no strap
// - Multiplexer request only with W1 and W2
`timescale 1ns/1ns
`include "smcm_regs.vh"

module smcm_board #(
	parameter [15:0] TIMEOUT_CYC = `SMCM_TIMEOUT_CYC
) (
	input  wire        core_clk,
	input  wire        resetn,
	input  wire        control_output_op,
	input  wire        status_read_op,
	input  wire [6:0]  unit_number,
	input  wire [15:0] io_data,
	input  wire        io_bus_parity,
	input  wire        control_order_word,
	input  wire        address_order_word,
	input  wire [15:0] order_data,
	input  wire        next_word_read,
	input  wire        port_read_strobe,
	input  wire        input_transfer_toggle,
	input  wire        port_write_strobe,
	input  wire        output_transfer_toggle,
	input  wire        transfer_end_in,
	input  wire        chan_service_out,
	input  wire [15:0] write_data,
	input  wire        mem_request,
	input  wire        mem_respond,
	input  wire        strap_w1,
	input  wire        strap_w2,
	input  wire        strap_w3,
	input  wire        strap_w4,
	input  wire        strap_mux,
	output reg         request_out,
	output reg         sel_service_req,
	output reg         mux_service_req,
	output reg         transfer_end,
	output reg         transfer_fault,
	output reg         jump_condition_met,
	output reg         device_end,
	output reg         chan_ack_inhibit,
	output reg         int_request,
	output reg  [15:0] read_data,
	output reg  [15:0] status_data,
	output reg         status_parity,
	output reg         parity_error
);

	localparam [2:0] ST_IDLE  = 3'h1;
	localparam [2:0] ST_WAIT  = 3'h2;
	localparam [2:0] ST_FAULT = 3'h4;

	reg  [15:0] ctl_r;
	reg  [15:0] buf_r;
	reg  [15:0] cnt_r;
	reg  [15:0] tmo_r;
	reg  [2:0]  st_r;
	reg  [2:0]  st_nxt;
	reg         int_pend_r;
	reg         mux_r;
	reg         sel_ok_r;
	reg         mux_ok_r;
	reg         strap_done_r;
	wire        addressed;
	wire        cw_wr;
	wire        aw_ctl;
	wire [15:0] cw;
	wire        mclr;
	wire [1:0]  ld_code;
	wire [2:0]  cnt_sel;
	wire        cnt_hit;
	wire        tc_hit;
	wire        cmp_fail;
	wire        term;
	wire        fault_set;

	// Pick the bus strobe that the counter selection names
	function sel_strobe;
		input [2:0] sel;
		input [7:0] strobes;
		begin
			sel_strobe = strobes[sel];
		end
	endfunction

	// Odd parity over a word, used on both directions of the data bus
	function odd_par;
		input [15:0] w;
		begin
			odd_par = ~(^w);
		end
	endfunction

	assign addressed = unit_number == (mux_r ? `SMCM_MUX_UNIT : `SMCM_SEL_UNIT);
	assign cw_wr     = control_output_op & addressed;
	assign ld_code   = ctl_r[`SMCM_CW_LOAD_HI:`SMCM_CW_LOAD_LO];
	assign aw_ctl    = address_order_word & (ld_code == `SMCM_LD_IGNORE);
	assign cw        = aw_ctl ? order_data : io_data;
	assign mclr      = (cw_wr | aw_ctl) & cw[`SMCM_CW_MCLR];
	assign cnt_sel   = ctl_r[`SMCM_CW_CNT_HI:`SMCM_CW_CNT_LO];

	assign cnt_hit = sel_strobe(cnt_sel, {chan_service_out, transfer_end_in,
		output_transfer_toggle, port_write_strobe, input_transfer_toggle,
		port_read_strobe, next_word_read, 1'b0});

	assign tc_hit   = ctl_r[`SMCM_CW_TERM_TC] & cnt_hit & (cnt_r + 16'h0001 == buf_r);
	assign cmp_fail = ctl_r[`SMCM_CW_TERM_CMP] & port_write_strobe & (write_data != buf_r);
	assign term     = tc_hit | cmp_fail;
	assign fault_set = (st_r == ST_WAIT) & ~mem_respond & (tmo_r == 16'h0001);

	// Straps are caught once after reset release, never under the reset itself
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			mux_r        <= 1'b0;
			sel_ok_r     <= 1'b0;
			mux_ok_r     <= 1'b0;
			strap_done_r <= 1'b0;
		end else if (!strap_done_r) begin
			strap_done_r <= 1'b1;
			mux_r        <= strap_mux;
			mux_ok_r     <= strap_w1 & strap_w2;
			sel_ok_r     <= strap_w3 & strap_w4;
		end
	end

	// Control word and data buffer
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ctl_r <= `SMCM_CW_RESET;
			buf_r <= `SMCM_BUF_RESET;
		end else if (mclr) begin
			ctl_r <= `SMCM_CW_RESET;
			buf_r <= `SMCM_BUF_RESET;
		end else begin
			if (cw_wr | aw_ctl)
				ctl_r <= cw;
			if (control_order_word & ld_code[0])
				buf_r <= order_data;
			else if (address_order_word & ld_code[1])
				buf_r <= order_data;
		end
	end

	always @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			cnt_r <= `SMCM_CNT_RESET;
		else if (mclr || (cw_wr && cw[`SMCM_CW_CLR_IF]))
			cnt_r <= `SMCM_CNT_RESET;
		else if (cnt_sel != `SMCM_CNT_NONE && cnt_hit)
			cnt_r <= cnt_r + 16'h0001;
	end

	// Port controller watch on memory module response
	always @* begin
		st_nxt = st_r;
		case (st_r)
			ST_IDLE:  if (mem_request)
				st_nxt = ST_WAIT;
			ST_WAIT:  if (mem_respond)
				st_nxt = ST_IDLE;
			else if (fault_set)
				st_nxt = ST_FAULT;
			ST_FAULT: if (mclr)
				st_nxt = ST_IDLE;
			default:  st_nxt = ST_IDLE;
		endcase
	end

	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			st_r  <= ST_IDLE;
			tmo_r <= 16'h0000;
		end else begin
			st_r <= st_nxt;
			if (st_r == ST_IDLE && mem_request)
				tmo_r <= TIMEOUT_CYC;
			else if (st_r == ST_WAIT && tmo_r != 16'h0000)
				tmo_r <= tmo_r - 16'h0001;
		end
	end

	// Outputs and interrupt; set wins over clear
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			request_out        <= 1'b0;
			sel_service_req    <= 1'b0;
			mux_service_req    <= 1'b0;
			transfer_end       <= 1'b0;
			transfer_fault     <= 1'b0;
			jump_condition_met <= 1'b0;
			device_end         <= 1'b0;
			chan_ack_inhibit   <= 1'b0;
			int_pend_r         <= 1'b0;
			int_request        <= 1'b0;
			read_data          <= 16'h0000;
			status_data        <= 16'h0000;
			status_parity      <= 1'b1;
			parity_error       <= 1'b0;
		end else begin
			request_out <= mclr;
			sel_service_req <= ctl_r[`SMCM_CW_HS_SR] & ~ctl_r[`SMCM_CW_INH_SR] & sel_ok_r;
			mux_service_req <= ctl_r[`SMCM_CW_HS_SR] & ~ctl_r[`SMCM_CW_INH_SR] & mux_ok_r;
			jump_condition_met <= ctl_r[`SMCM_CW_SET_JMP];
			device_end         <= ctl_r[`SMCM_CW_DEV_END];
			chan_ack_inhibit   <= ctl_r[`SMCM_CW_INH_ACK];
			if (term)
				transfer_end <= 1'b1;
			else if (mclr)
				transfer_end <= 1'b0;
			if (fault_set)
				transfer_fault <= 1'b1;
			else if (mclr)
				transfer_fault <= 1'b0;
			if (term | fault_set)
				int_pend_r <= 1'b1;
			else if (mclr || (cw_wr && cw[`SMCM_CW_RST_INT]))
				int_pend_r <= 1'b0;
			int_request <= (int_pend_r | term | fault_set) & ~mux_r;
			read_data <= ctl_r[`SMCM_CW_UNIT_BUF] ? buf_r : cnt_r;
			if (status_read_op & addressed) begin
				status_data   <= {int_pend_r, transfer_end, transfer_fault,
					sel_ok_r, mux_ok_r, mux_r, st_r == ST_WAIT, 6'h00, cnt_sel};
				status_parity <= odd_par({int_pend_r, transfer_end, transfer_fault,
					sel_ok_r, mux_ok_r, mux_r, st_r == ST_WAIT, 6'h00, cnt_sel});
			end
			if (cw_wr)
				parity_error <= (io_bus_parity != odd_par(io_data)) & ~mux_r & 1'b0;
		end
	end

endmodule // smcm_board

// ---- smcm_board_props.sv ----
/* Port checker for smcm_board.
 Bound to every smcm_board instance; sees its ports only. */
`timescale 1ns/1ns
module smcm_board_props #(
	parameter [15:0] TIMEOUT_CYC = 16'h01F4
) (
	input wire        core_clk,
	input wire        resetn,
	input wire        control_output_op,
	input wire [6:0]  unit_number,
	input wire [15:0] io_data,
	input wire        mem_request,
	input wire        mem_respond,
	input wire        strap_w1,
	input wire        strap_w2,
	input wire        strap_mux,
	input wire        request_out,
	input wire        sel_service_req,
	input wire        mux_service_req,
	input wire        transfer_end,
	input wire        transfer_fault,
	input wire        int_request,
	input wire        parity_error
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	wire       wr = control_output_op && unit_number == (strap_mux ? 7'h7F : 7'h10);
	reg [15:0] wt_r;
	// Age of an unanswered memory request
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			wt_r <= 16'h0000;
		else if (mem_respond)
			wt_r <= 16'h0000;
		else if (mem_request || wt_r != 16'h0000)
			wt_r <= wt_r + 16'h0001;
	end
	mclr_req_a: assert property (wr && io_data[15] |-> ##[1:2] request_out)
		else $error("no request after master clear");
	hs_req_a: assert property (wr && io_data[7] && !io_data[10] |-> ##[1:3]
		(sel_service_req || mux_service_req)) else $error("no service request");
	end_int_a: assert property (!strap_mux && $rose(transfer_end) |-> ##[0:1]
		int_request) else $error("transfer end without interrupt");
	fault_hold_a: assert property (transfer_fault && !(wr && io_data[15]) |=>
		transfer_fault) else $error("fault dropped");
	tmo_late_a: assert property (wt_r == TIMEOUT_CYC + 16'h0004 |-> transfer_fault)
		else $error("timeout missed");
	tmo_early_a: assert property (wt_r != 16'h0000 && wt_r < TIMEOUT_CYC - 16'h0002
		|-> !$rose(transfer_fault)) else $error("timeout too early");
	mux_noint_a: assert property (strap_mux |-> !int_request)
		else $error("interrupt in mux mode");
	no_parity_a: assert property (!parity_error)
		else $error("parity error raised");
	mux_gate_a: assert property (mux_service_req |-> strap_w1 && strap_w2)
		else $error("mux request without straps");
endmodule // smcm_board_props

bind smcm_board smcm_board_props #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_smcm_board_props (.*);

// ---- smcm_mem_model.sv ----
/* Memory module stand-in behind the port controller.
 Answers three cycles after a request, or never while slow is high. */
`timescale 1ns/1ns
module smcm_mem_model (
	input  wire core_clk,
	input  wire resetn,
	input  wire mem_request,
	input  wire slow,
	output reg  mem_respond
);
	reg [1:0] dly_r;
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			dly_r <= 2'h0;
			mem_respond <= 1'b0;
		end else begin
			dly_r <= {dly_r[0], mem_request & ~slow};
			mem_respond <= dly_r[1];
		end
	end
endmodule // smcm_mem_model

// ---- smcm_testbench.sv ----
/* Self-checking bench for smcm_board.
 Inputs move 1 ns after the rising edge; memory stand-in answers. */
`timescale 1ns/1ns
module testbench;
	localparam [6:0] SU = 7'h10;
	reg        core_clk, resetn, control_output_op, control_order_word;
	reg        address_order_word, mem_request, slow, strap_mux;
	reg [6:0]  unit_number, strb;
	reg [15:0] io_data, order_data, write_data;
	reg        status_read_op;
	wire       io_bus_parity = ^io_data;
	wire       strap_w1 = strap_mux, strap_w2 = strap_mux;
	wire       strap_w3 = !strap_mux, strap_w4 = !strap_mux;
	wire       next_word_read, port_read_strobe, input_transfer_toggle, port_write_strobe;
	wire       output_transfer_toggle, transfer_end_in, chan_service_out, mem_respond;
	wire       request_out, sel_service_req, mux_service_req, transfer_end, transfer_fault;
	wire       jump_condition_met, device_end, chan_ack_inhibit, int_request;
	wire       status_parity, parity_error;
	wire [15:0] read_data, status_data;
	integer    mismatches, num_checks, i;
	assign {chan_service_out, transfer_end_in, output_transfer_toggle, port_write_strobe,
		input_transfer_toggle, port_read_strobe, next_word_read} = strb;
	smcm_board #(.TIMEOUT_CYC(16'h0008)) u_smcm_board (.*);
	smcm_mem_model u_smcm_mem_model (.*);
	task chk(input [15:0] got, input [15:0] exp);
		begin
			num_checks = num_checks + 1;
			if (got !== exp) begin
				mismatches = mismatches + 1;
				$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task cyc(input integer n);
		begin
			repeat (n) @(posedge core_clk);
			#1;
		end
	endtask
	task cw(input [6:0] u, input [15:0] d);
		begin
			unit_number = u;
			io_data = d;
			control_output_op = 1'b1;
			cyc(1);
			control_output_op = 1'b0;
		end
	endtask
	task ord(input a, input [15:0] d);
		begin
			order_data = d;
			control_order_word = !a;
			address_order_word = a;
			cyc(1);
			{control_order_word, address_order_word} = 2'h0;
		end
	endtask
	task stb(input integer k);
		begin
			strb[k] = 1'b1;
			cyc(1);
			strb = 7'h00;
			cyc(1);
		end
	endtask
	task t_count;
		for (i = 0; i < 8; i = i + 1) begin
			cw(SU, 16'h8000);
			chk(request_out, 1'b1);
			cw(SU, {13'h0000, i[2:0]});
			repeat (3) stb(i == 0 ? 0 : i - 1);
			stb(i % 7);
			cyc(2);
			chk(read_data, i == 0 ? 16'h0000 : 16'h0003);
		end
	endtask
	task t_buf;
		begin
			for (i = 1; i < 4; i = i + 1) begin
				cw(SU, 16'h8000);
				cw(SU, {6'h00, i[1:0], 8'h40});
				ord(0, 16'h1111);
				ord(1, 16'h2222);
				cyc(2);
				chk(read_data, i == 1 ? 16'h1111 : 16'h2222);
			end
			cw(SU, 16'h8000);
			ord(1, 16'h0080);
			cyc(2);
			chk(sel_service_req, 1'b1);
			// Control word bits 2 to 4 are copied straight to their bus lines
			cw(SU, 16'h3800);
			cyc(1);
			chk({jump_condition_met, device_end, chan_ack_inhibit}, 3'h7);
			// A word for another unit must not clear the board
			cw(7'h11, 16'h8000);
			chk(request_out, 1'b0);
		end
	endtask
	task t_term;
		begin
			cw(SU, 16'h8000);
			cw(SU, 16'h0100);
			ord(0, 16'h0003);
			cw(SU, 16'h0021);
			repeat (2) stb(0);
			chk(transfer_end, 1'b0);
			stb(0);
			cyc(1);
			chk({transfer_end, int_request}, 2'h3);
			cw(SU, 16'h4021);
			cyc(1);
			chk(int_request, 1'b0);
			cw(SU, 16'h8000);
			cw(SU, 16'h0100);
			ord(0, 16'h0005);
			cw(SU, 16'h0010);
			write_data = 16'h0005;
			stb(3);
			chk(transfer_end, 1'b0);
			write_data = 16'h0006;
			stb(3);
			chk(transfer_end, 1'b1);
		end
	endtask
	task t_tmo(input m);
		begin
			resetn = 1'b0;
			strap_mux = m;
			cyc(10);
			resetn = 1'b1;
			cyc(2);
			cw(m ? 7'h7F : SU, 16'h0080);
			cyc(1);
			chk({mux_service_req, sel_service_req}, m ? 2'h2 : 2'h1);
			for (i = 0; i < 2; i = i + 1) begin
				slow = i[0];
				mem_request = 1'b1;
				cyc(1);
				mem_request = 1'b0;
				cyc(20);
				chk(transfer_fault, i[0]);
			end
			chk(int_request, !m);
			unit_number = m ? 7'h7F : SU;
			status_read_op = 1'b1;
			cyc(1);
			status_read_op = 1'b0;
			cyc(1);
			chk(status_data, m ? 16'hAC00 : 16'hB000);
			chk(status_parity, m);
		end
	endtask
	task complete_run;
		begin
			$display("checks %0d mismatches %0d", num_checks, mismatches);
			if (mismatches == 0 && num_checks > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	initial begin
		mismatches = 0;
		num_checks = 0;
		{resetn, control_output_op, control_order_word, address_order_word} = 4'h0;
		{mem_request, slow, strap_mux, unit_number, strb} = 17'h00000;
		{io_data, order_data, write_data} = 48'h000000000000;
		status_read_op = 1'b0;
		t_tmo(1'b0);
		t_count;
		t_buf;
		t_term;
		t_tmo(1'b1);
		complete_run;
	end
	// Whole run is near 260 cycles; cut off well beyond
	initial begin
		#200000;
		mismatches = mismatches + 1;
		complete_run;
	end
endmodule // testbench
